// File: vic_defines.vh
/*
 * constants of the vectored interrupt and trap arbiter: register map,
 * control register field positions, vector numbers and reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// per-source control registers, one word each from this base
`define VIC_CTRL_BASE       12'h000
// processor status word image (global enable, cpu level)
`define VIC_PSW_ADDR        12'h080
// trap flag register
`define VIC_TRAP_ADDR       12'h084
// last vector taken, read only
`define VIC_VEC_ADDR        12'h088

// control register lower byte layout
`define VIC_PEND_BIT        7
`define VIC_EN_BIT          6
`define VIC_PLVL_HI         5
`define VIC_PLVL_LO         2
`define VIC_GRP_HI          1
`define VIC_GRP_LO          0
`define VIC_CTRL_RESET      8'h00

// processor status word image layout
`define VIC_PSW_IEN_BIT     11
`define VIC_PSW_LVL_HI      15
`define VIC_PSW_LVL_LO      12
`define VIC_PSW_RESET       16'h0000
`define VIC_LVL_MAX         4'hF

// trap flag register layout
`define VIC_TF_NMI          15
`define VIC_TF_STACK_OVERFLOW_FLAG        14
`define VIC_TF_STACK_UNDERFLOW_FLAG        13
`define VIC_TF_B_LO         0
`define VIC_TF_B_HI         4

// trap numbers
`define VIC_TN_RESET        7'h00
`define VIC_TN_NMI          7'h02
`define VIC_TN_STACK_OVERFLOW_FLAG        7'h04
`define VIC_TN_STACK_UNDERFLOW_FLAG        7'h06
`define VIC_TN_CLASS_B      7'h0A

// vector address = trap number * bytes per entry
`define VIC_ENTRY_SHIFT     2

`endif

// File: vic_winner.v
/*
 * single-pass priority search over all request nodes: priority level first,
 * group level second. pure combinational.
 * assumes packed per-node fields from the same clock domain.
 */
`timescale 1ns/1ps
module vic_winner #(
    parameter N_SRC = 20,
    parameter IW    = 5
) (
    input  wire [N_SRC-1:0]   i_req,
    input  wire [N_SRC*4-1:0] i_plvl,
    input  wire [N_SRC*2-1:0] i_grp,
    output reg                o_any,
    output reg  [IW-1:0]      o_idx,
    output reg  [3:0]         o_lvl
);
    reg [5:0] best;
    reg [5:0] key;
    integer   k;

    always @* begin
        best  = 6'h00;
        key   = 6'h00;
        o_any = 1'b0;
        o_idx = {IW{1'b0}};
        o_lvl = 4'h0;
        for (k = 0; k < N_SRC; k = k + 1) begin
            // level in upper bits, group in lower bits
            key = {i_plvl[k*4 +: 4], i_grp[k*2 +: 2]};
            if (i_req[k] && (!o_any || key > best)) begin
                o_any = 1'b1;
                best  = key;
                o_idx = k[IW-1:0];
                o_lvl = i_plvl[k*4 +: 4];
            end
        end
    end
endmodule

// File: vic_arbiter.v
/*
 * vectored interrupt and trap arbiter with apb register access.
 * assumes i_sys_clk is the cpu instruction-cycle clock, request and trap
 * event inputs are pulses from logic on the same clock, the cpu core
 * acknowledges a taken vector with i_cpu_ack, and the nmi pin is async.
 */
// Implementation choices: the APB register port and the register addresses.
// What this block does
// - twenty request nodes, sixteen priority levels
// - each source has control register, vector
// - serviced source branches to own vector
// - class b traps share one vector, flags
// - vector address is trap number times four
// - any reset vectors to zero, outranks all
// - nmi, stack overflow, underflow class a vectors
// - software trap takes seven-bit trap number
// - software trap keeps cpu level unchanged
// - arbitrate all pending requests every cycle
// - serve only if above cpu level
// - group level breaks equal-level ties
// - need source enable and global enable
// - upper byte reads zero, writes dropped
// - all low bits readable and writable
// - group value three highest, zero lowest
// - level f highest, zero lowest
// - enable zero blocks, one allows
// - pending flag shows outstanding request
// - table at low segment-zero addresses
// - hardware sets flag, entry clears it
// - push old status, then load level
`timescale 1ns/1ps
`include "vic_defines.vh"
module vic_arbiter #(
    parameter N_SRC = 20,
    parameter IW    = 5
) (
    input  wire              i_sys_clk,
    input  wire              i_rstn,
    input  wire              i_ce,
    input  wire [11:0]       i_paddr,
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [31:0]       i_pwdata,
    input  wire [3:0]        i_pstrb,
    output reg  [31:0]       o_prdata,
    output reg               o_pready,
    output reg               o_pslverr,
    input  wire [N_SRC-1:0]  i_src_req,
    input  wire              i_nmi_pin,
    input  wire              i_stack_overflow_flag,
    input  wire              i_stack_underflow_flag,
    input  wire [4:0]        i_class_b,
    input  wire              i_sw_trap,
    input  wire [6:0]        i_sw_trap_num,
    input  wire              i_sw_reset,
    input  wire              i_wdt_reset,
    input  wire              i_cpu_ack,
    output reg               o_vec_valid,
    output reg  [8:0]        o_vec_addr,
    output reg               o_psw_push,
    output reg  [15:0]       o_psw_old
);
    // control registers, lower byte only
    reg  [7:0]          ctrl_r [0:N_SRC-1];
    reg  [15:0]         psw_r;
    reg  [15:0]         tf_r;
    reg  [6:0]          last_tn_r;
    reg                 nmi_s1_r;
    reg                 nmi_s2_r;
    reg                 nmi_d_r;
    reg                 busy_r;
    reg                 sel_src_r;
    reg  [IW-1:0]       sel_idx_r;

    wire [N_SRC-1:0]    req_ok;
    wire [N_SRC*4-1:0]  plvl_bus;
    wire [N_SRC*2-1:0]  grp_bus;
    wire                win_any;
    wire [IW-1:0]       win_idx;
    wire [3:0]          win_lvl;
    wire                apb_wr;
    wire                apb_rd;
    wire                nmi_rise;
    wire                ctrl_hit;
    wire [2:0]          sel_code;
    wire [9:0]          word_idx;
    wire                global_request_enable;
    wire [3:0]          cpu_lvl;

    // register decode codes
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_CTRL = 3'h1;
    localparam [2:0] SEL_PSW  = 3'h2;
    localparam [2:0] SEL_TRAP = 3'h3;
    localparam [2:0] SEL_VEC  = 3'h4;

    // register decode, shared by the write and the read path
    function [2:0] reg_sel;
        input [11:0] a;
        begin
            if (a < (`VIC_CTRL_BASE + 12'h004 * N_SRC[11:0])) begin
                reg_sel = SEL_CTRL;
            end else if (a == `VIC_PSW_ADDR) begin
                reg_sel = SEL_PSW;
            end else if (a == `VIC_TRAP_ADDR) begin
                reg_sel = SEL_TRAP;
            end else if (a == `VIC_VEC_ADDR) begin
                reg_sel = SEL_VEC;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    // a write lands once, at the completing edge where pready is high
    assign apb_wr   = i_psel && i_penable && i_pwrite && i_ce && o_pready;
    assign apb_rd   = i_psel && i_penable && !i_pwrite && i_ce;
    assign word_idx = i_paddr[11:2];
    assign sel_code = reg_sel(i_paddr);
    assign ctrl_hit = (sel_code == SEL_CTRL);
    assign global_request_enable      = psw_r[`VIC_PSW_IEN_BIT];
    assign cpu_lvl  = psw_r[`VIC_PSW_LVL_HI:`VIC_PSW_LVL_LO];
    assign nmi_rise = nmi_s2_r && !nmi_d_r;

    // vector byte address from trap number
    function [8:0] vec_of;
        input [6:0] tn;
        begin
            vec_of = {tn, 2'b00} << 0;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < N_SRC; g = g + 1) begin : gen_src
            // request qualifies with pending flag and both enables; cpu level is checked on the winner
            assign req_ok[g] = ctrl_r[g][`VIC_PEND_BIT] && ctrl_r[g][`VIC_EN_BIT]
                               && global_request_enable;
            assign plvl_bus[g*4 +: 4] = ctrl_r[g][`VIC_PLVL_HI:`VIC_PLVL_LO];
            assign grp_bus[g*2 +: 2]  = ctrl_r[g][`VIC_GRP_HI:`VIC_GRP_LO];
        end
    endgenerate

    // group ties must be distinct by software or the lowest source index wins
    vic_winner #(
        .N_SRC (N_SRC),
        .IW    (IW)
    ) u_winner (
        .i_req  (req_ok),
        .i_plvl (plvl_bus),
        .i_grp  (grp_bus),
        .o_any  (win_any),
        .o_idx  (win_idx),
        .o_lvl  (win_lvl)
    );

    // trap number per source, arbitrary consecutive block from 18h
    function [6:0] src_tn;
        input [IW-1:0] idx;
        begin
            src_tn = 7'h18 + {2'b00, idx};
        end
    endfunction

    // nmi pin synchroniser and edge detect
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            nmi_s1_r <= 1'b0;
            nmi_s2_r <= 1'b0;
            nmi_d_r  <= 1'b0;
        end else if (i_ce) begin
            nmi_s1_r <= i_nmi_pin;
            nmi_s2_r <= nmi_s1_r;
            nmi_d_r  <= nmi_s2_r;
        end
    end

    // vector issue, status and control registers
    integer i;
    reg          take_hw;
    reg  [6:0]   tn_nxt;
    reg  [15:0]  psw_nxt;
    reg  [15:0]  tf_set;

    always @* begin
        take_hw = 1'b0;
        tn_nxt  = `VIC_TN_RESET;
        psw_nxt = psw_r;
        tf_set  = 16'h0000;
        tf_set[`VIC_TF_NMI]   = nmi_rise;
        tf_set[`VIC_TF_STACK_OVERFLOW_FLAG] = i_stack_overflow_flag;
        tf_set[`VIC_TF_STACK_UNDERFLOW_FLAG] = i_stack_underflow_flag;
        tf_set[`VIC_TF_B_HI:`VIC_TF_B_LO] = i_class_b;
        if (i_sw_reset || i_wdt_reset) begin
            tn_nxt  = `VIC_TN_RESET;
            take_hw = 1'b1;
            psw_nxt = `VIC_PSW_RESET;
        end else if (nmi_rise || tf_r[`VIC_TF_NMI]) begin
            tn_nxt  = `VIC_TN_NMI;
            take_hw = 1'b1;
        end else if (i_stack_overflow_flag || tf_r[`VIC_TF_STACK_OVERFLOW_FLAG]) begin
            tn_nxt  = `VIC_TN_STACK_OVERFLOW_FLAG;
            take_hw = 1'b1;
        end else if (i_stack_underflow_flag || tf_r[`VIC_TF_STACK_UNDERFLOW_FLAG]) begin
            tn_nxt  = `VIC_TN_STACK_UNDERFLOW_FLAG;
            take_hw = 1'b1;
        end else if ((|i_class_b) || (|tf_r[`VIC_TF_B_HI:`VIC_TF_B_LO])) begin
            tn_nxt  = `VIC_TN_CLASS_B;
            take_hw = 1'b1;
        end
        // hardware traps other than reset run at the top cpu level
        if (take_hw && !(i_sw_reset || i_wdt_reset)) begin
            psw_nxt[`VIC_PSW_LVL_HI:`VIC_PSW_LVL_LO] = `VIC_LVL_MAX;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            for (i = 0; i < N_SRC; i = i + 1) begin
                ctrl_r[i] <= `VIC_CTRL_RESET;
            end
            psw_r       <= `VIC_PSW_RESET;
            tf_r        <= 16'h0000;
            last_tn_r   <= `VIC_TN_RESET;
            busy_r      <= 1'b1;
            sel_src_r   <= 1'b0;
            sel_idx_r   <= {IW{1'b0}};
            o_vec_valid <= 1'b1;
            o_vec_addr  <= 9'h000;
            o_psw_push  <= 1'b0;
            o_psw_old   <= 16'h0000;
        end else if (i_ce) begin
            o_psw_push <= 1'b0;
            // hardware sets pending flags; set wins over a software clear
            for (i = 0; i < N_SRC; i = i + 1) begin
                if (apb_wr && ctrl_hit && word_idx == i && i_pstrb[0]) begin
                    ctrl_r[i] <= i_pwdata[7:0];
                end
                if (i_src_req[i]) begin
                    ctrl_r[i][`VIC_PEND_BIT] <= 1'b1;
                end
            end
            if (apb_wr && sel_code == SEL_PSW) begin
                if (i_pstrb[0]) psw_r[7:0] <= i_pwdata[7:0];
                if (i_pstrb[1]) psw_r[15:8] <= i_pwdata[15:8];
            end
            // trap flags: software clears by writing ones, events win
            if (apb_wr && sel_code == SEL_TRAP) begin
                tf_r <= (tf_r & ~i_pwdata[15:0]) | tf_set;
            end else begin
                tf_r <= tf_r | tf_set;
            end
            if (busy_r) begin
                if (i_cpu_ack) begin
                    busy_r      <= 1'b0;
                    o_vec_valid <= 1'b0;
                    if (sel_src_r) begin
                        // entry clears the flag, set still wins
                        if (!i_src_req[sel_idx_r]) begin
                            ctrl_r[sel_idx_r][`VIC_PEND_BIT] <= 1'b0;
                        end
                    end
                end
            end else if (take_hw) begin
                // traps are not gated by global enable
                busy_r      <= 1'b1;
                sel_src_r   <= 1'b0;
                o_vec_valid <= 1'b1;
                o_vec_addr  <= vec_of(tn_nxt);
                last_tn_r   <= tn_nxt;
                o_psw_push  <= (tn_nxt != `VIC_TN_RESET);
                o_psw_old   <= psw_r;
                psw_r       <= psw_nxt;
                if (tn_nxt == `VIC_TN_NMI) tf_r[`VIC_TF_NMI] <= 1'b0;
            end else if (i_sw_trap) begin
                busy_r      <= 1'b1;
                sel_src_r   <= 1'b0;
                o_vec_valid <= 1'b1;
                o_vec_addr  <= vec_of(i_sw_trap_num);
                last_tn_r   <= i_sw_trap_num;
                o_psw_push  <= 1'b1;
                o_psw_old   <= psw_r;
            end else if (win_any && win_lvl > cpu_lvl) begin
                busy_r      <= 1'b1;
                sel_src_r   <= 1'b1;
                sel_idx_r   <= win_idx;
                o_vec_valid <= 1'b1;
                o_vec_addr  <= vec_of(src_tn(win_idx));
                last_tn_r   <= src_tn(win_idx);
                o_psw_push  <= 1'b1;
                o_psw_old   <= psw_r;
                psw_r[`VIC_PSW_LVL_HI:`VIC_PSW_LVL_LO] <= win_lvl;
            end
        end
    end

    // apb slave: one wait state, read data and error stand with pready
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready  <= i_psel && i_penable && !o_pready;
            o_pslverr <= 1'b0;
            if (apb_rd && !o_pready) begin
                case (sel_code)
                    SEL_CTRL: begin
                        o_prdata <= {24'h000000, ctrl_r[word_idx[IW-1:0]]};
                    end
                    SEL_PSW: begin
                        o_prdata <= {16'h0000, psw_r};
                    end
                    SEL_TRAP: begin
                        o_prdata <= {16'h0000, tf_r};
                    end
                    SEL_VEC: begin
                        o_prdata <= {23'h000000, vec_of(last_tn_r)};
                    end
                    default: begin
                        o_prdata  <= 32'h0000_0000;
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// File: vic_arbiter_sva.sv
/* port assertions of the interrupt arbiter.
   assumes a bind onto vic_arbiter and one clock domain. */
`timescale 1ns/1ps
module vic_arbiter_sva (
    input wire       i_sys_clk,
    input wire       i_rstn,
    input wire       i_ce,
    input wire       i_psel,
    input wire       i_penable,
    input wire       o_pready,
    input wire       o_pslverr,
    input wire       i_sw_reset,
    input wire       i_wdt_reset,
    input wire       i_cpu_ack,
    input wire       o_vec_valid,
    input wire [8:0] o_vec_addr,
    input wire       o_psw_push
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    ready_wait_a: assert property (i_ce && i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready late");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready too long");
    slverr_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    vec_hold_a: assert property (o_vec_valid && !i_cpu_ack |=> o_vec_valid && $stable(o_vec_addr))
        else $error("vector not held");
    vec_drop_a: assert property (o_vec_valid && i_cpu_ack && i_ce |=> !o_vec_valid)
        else $error("vector not released");
    addr_align_a: assert property (o_vec_valid |-> o_vec_addr[1:0] == 2'h0)
        else $error("vector not word aligned");
    reset_vec_a: assert property ((i_sw_reset || i_wdt_reset) && !o_vec_valid
        |-> ##[1:2] o_vec_valid && o_vec_addr == 9'h000)
        else $error("reset vector missing");
    push_issue_a: assert property ($rose(o_vec_valid) && o_vec_addr != 9'h000 |-> o_psw_push)
        else $error("status not pushed");
    push_pulse_a: assert property (o_psw_push |=> !o_psw_push)
        else $error("push too long");
endmodule
bind vic_arbiter vic_arbiter_sva u_sva (.i_sys_clk, .i_rstn, .i_ce, .i_psel, .i_penable,
    .o_pready, .o_pslverr, .i_sw_reset, .i_wdt_reset, .i_cpu_ack, .o_vec_valid,
    .o_vec_addr, .o_psw_push);

// File: vic_cpu_model.sv
/* cpu core model: takes each vector after 0 to 3 cycles.
   assumes the arbiter holds o_vec_valid until the ack. */
`timescale 1ns/1ps
module vic_cpu_model (
    input  wire        i_sys_clk,
    input  wire        i_rstn,
    input  wire        i_vec_valid,
    input  wire [8:0]  i_vec_addr,
    output reg         o_cpu_ack,
    output reg  [8:0]  o_last_addr,
    output reg  [31:0] o_n_taken
);
    reg [1:0] wait_r;
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_cpu_ack <= 1'h0;
            wait_r <= 2'h0;
            o_n_taken <= 32'h0;
            o_last_addr <= 9'h000;
        end else if (o_cpu_ack) begin
            o_cpu_ack <= 1'h0;
        end else if (i_vec_valid) begin
            if (wait_r == 2'h0) begin
                o_cpu_ack <= 1'h1;
                o_last_addr <= i_vec_addr;
                o_n_taken <= o_n_taken + 32'h1;
                wait_r <= 2'($urandom);
            end else begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule

// File: tb_top.sv
/* self-checking bench of the arbiter: apb master, event pulses, cpu model.
   assumes vic_arbiter, vic_cpu_model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    reg clk, rstn, psel, penable, pwrite, nmi, stack_overflow_flag, stack_underflow_flag, sw_trap, sw_reset, wdt_reset;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd, d;
    reg [19:0] src_req, mask;
    reg [4:0]  class_b;
    reg [6:0]  sw_num;
    reg [3:0]  cl;
    reg        er, global_request_enable, ce;
    wire [15:0] psw_old;
    wire [31:0] prdata, n_taken;
    wire       pready, pslverr, ack, vec_valid, psw_push;
    wire [8:0] vec_addr, last_addr;
    integer error_cnt, n_compared, i, k, r, b, t, n0, exp_i;
    reg [7:0]  ctl [0:19];
    reg [8:0]  tva [0:6] = '{9'h010, 9'h018, 9'h028, 9'h008, 9'h1FC, 9'h000, 9'h000};
    reg [15:0] tfm [0:2] = '{16'h4000, 16'h2000, 16'h0004};

    vic_arbiter DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_paddr(paddr),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
        .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_src_req(src_req), .i_nmi_pin(nmi), .i_stack_overflow_flag(stack_overflow_flag), .i_stack_underflow_flag(stack_underflow_flag),
        .i_class_b(class_b), .i_sw_trap(sw_trap), .i_sw_trap_num(sw_num),
        .i_sw_reset(sw_reset), .i_wdt_reset(wdt_reset), .i_cpu_ack(ack),
        .o_vec_valid(vec_valid), .o_vec_addr(vec_addr), .o_psw_push(psw_push),
        .o_psw_old(psw_old));
    vic_cpu_model u_cpu (.i_sys_clk(clk), .i_rstn(rstn), .i_vec_valid(vec_valid),
        .i_vec_addr(vec_addr), .o_cpu_ack(ack), .o_last_addr(last_addr), .o_n_taken(n_taken));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task end_of_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== ex) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0s expected %h seen %h", nm, ex, got);
            end
        end
    endtask

    task apb(input w, input [11:0] a, input [31:0] wd);
        begin
            @(posedge clk);
            psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= wd;
            @(posedge clk);
            penable <= 1'h1;
            @(posedge clk);
            while (pready !== 1'h1) @(posedge clk);
            rd = prdata;
            er = pslverr;
            psel <= 1'h0; penable <= 1'h0;
        end
    endtask

    task wait_vec;
        for (t = 0; t < 40 && n_taken == n0; t = t + 1) @(posedge clk);
    endtask

    function integer win(input [3:0] c);
        integer j;
        begin
            win = -1;
            for (j = 0; j < 20; j = j + 1)
                if (ctl[j][7] && ctl[j][6] && ctl[j][5:2] > c
                    && (win < 0 || ctl[j][5:0] > ctl[win][5:0])) win = j;
        end
    endfunction

    initial begin
        error_cnt = 0; n_compared = 0; rstn = 1'h0; psel = 1'h0; penable = 1'h0;
        pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0; src_req = 20'h0; nmi = 1'h0;
        stack_overflow_flag = 1'h0; stack_underflow_flag = 1'h0; class_b = 5'h00; sw_trap = 1'h0; sw_num = 7'h00;
        sw_reset = 1'h0; wdt_reset = 1'h0;
        ce = 1'h1;
        i = $urandom(5);
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        n0 = 0; wait_vec;
        chk("reset vector", 0, last_addr);
        for (i = 0; i < 20; i = i + 1) begin
            d = $urandom;
            apb(0, 12'(i * 4), 0); chk("ctrl reset", 0, rd);
            apb(1, 12'(i * 4), d); apb(0, 12'(i * 4), 0);
            chk("ctrl rw", {24'h0, d[7:0]}, rd);
            apb(1, 12'(i * 4), 0);
        end
        apb(0, 12'hFFC, 0); chk("unmapped err", 1, er); chk("unmapped data", 0, rd);
        for (r = 0; r < 6; r = r + 1) begin
            for (i = 0; i < 20; i = i + 1) ctl[i] = 8'h00;
            b = ($urandom % 6) * 3; mask = 20'h0;
            for (k = 0; k < 3; k = k + 1) begin
                ctl[b+k] = {1'h0, ($urandom % 4) != 0, 4'($urandom), 2'(k)};
                apb(1, 12'((b + k) * 4), ctl[b+k]);
                mask[b+k] = 1'h1; ctl[b+k][7] = 1'h1;
            end
            cl = 4'($urandom % 4); global_request_enable = (r != 1);
            apb(1, 12'h080, {16'h0, cl, global_request_enable, 11'h0});
            n0 = n_taken;
            src_req <= mask; @(posedge clk); src_req <= 20'h0;
            exp_i = global_request_enable ? win(cl) : -1;
            wait_vec;
            if (exp_i >= 0) begin
                chk("vector", (24 + exp_i) * 4, last_addr);
                chk("old status", {cl, global_request_enable, 11'h0}, psw_old);
                apb(0, 12'h088, 0); chk("last vector", (24 + exp_i) * 4, rd);
                apb(0, 12'h080, 0); chk("cpu level", ctl[exp_i][5:2], rd[15:12]);
                apb(0, 12'(exp_i * 4), 0); chk("pend clear", ctl[exp_i] & 8'h7F, rd);
            end else begin
                chk("no vector", n0, n_taken);
                apb(0, 12'(b * 4), 0); chk("pend set", ctl[b], rd);
            end
            for (k = 0; k < 3; k = k + 1) apb(1, 12'((b + k) * 4), 0);
            apb(1, 12'h080, 0);
        end
        for (k = 0; k < 7; k = k + 1) begin
            apb(1, 12'h080, {16'h0, 4'h5, 1'h1, 11'h0});
            n0 = n_taken;
            case (k)
                0: stack_overflow_flag <= 1'h1;
                1: stack_underflow_flag <= 1'h1;
                2: class_b <= 5'h04;
                3: nmi <= 1'h1;
                4: begin sw_trap <= 1'h1; sw_num <= 7'h7F; end
                5: sw_reset <= 1'h1;
                default: wdt_reset <= 1'h1;
            endcase
            @(posedge clk);
            stack_overflow_flag <= 1'h0; stack_underflow_flag <= 1'h0; class_b <= 5'h00; sw_trap <= 1'h0;
            sw_reset <= 1'h0; wdt_reset <= 1'h0;
            wait_vec;
            nmi <= 1'h0;
            chk("trap vector", tva[k], last_addr);
            if (k < 5) begin
                apb(0, 12'h080, 0); chk("trap level", (k == 4) ? 5 : 15, rd[15:12]);
            end
            if (k < 3) begin
                apb(0, 12'h084, 0); chk("trap flag", tfm[k], rd & tfm[k]);
                apb(1, 12'h084, tfm[k]);
            end
            repeat (20) @(posedge clk);
        end
        n0 = n_taken;
        ce <= 1'h0;
        sw_trap <= 1'h1;
        sw_num <= 7'h21;
        @(posedge clk);
        sw_trap <= 1'h0;
        ce <= 1'h1;
        repeat (10) @(posedge clk);
        chk("frozen trap", n0, n_taken);
        end_of_test;
    end

    initial begin
        #(25 * 40000);
        error_cnt = error_cnt + 1;
        end_of_test;
    end
endmodule
